// File: rtl/acfs_defines.vh
`ifndef ACFS_DEFINES_VH
`define ACFS_DEFINES_VH

// register byte offsets on the apb bus
`define ACFS_OFF_CTRL 12'h000
`define ACFS_OFF_SLOT_EN 12'h004
`define ACFS_OFF_STATUS 12'h008
`define ACFS_OFF_RX_TAG 12'h00c
`define ACFS_OFF_FRAME_CNT 12'h010
// buffer windows, selected by address bits 7:6
`define ACFS_WIN_RX 2'b01
`define ACFS_WIN_TX 2'b10

// control register fields
`define ACFS_CTRL_ENABLE 0
`define ACFS_CTRL_RST 32'h0000_0000

// slot enable register: receive mask low half, transmit mask high half
`define ACFS_SLOT_EN_RST 32'h001f_001f

// status register fields
`define ACFS_ST_RX_DONE 0
`define ACFS_ST_TX_DONE 1
`define ACFS_ST_LEFT_VALID 2
`define ACFS_ST_RIGHT_VALID 3

// tag word bit positions in slot 0
`define ACFS_TAG_FRAME_VALID 15
`define ACFS_TAG_LEFT 12
`define ACFS_TAG_RIGHT 11

// frame geometry
`define ACFS_SLOT_BITS 16
`define ACFS_SLOTS 16
`define ACFS_LEFT_SLOT 4'h3
`define ACFS_RIGHT_SLOT 4'h4

`endif

// File: rtl/acfs_shifter.v
`timescale 1ns/1ps
`include "acfs_defines.vh"

// link-side shifter: samples bit clock, frame sync and data with pclk
module acfs_shifter (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // link pins
  input wire bit_clk,
  input wire frame_sync,
  input wire sdata_in,
  output reg sdata_out,
  // word interface toward the slot handler
  input wire [15:0] tx_word,
  output wire [3:0] fetch_slot,
  output reg tx_load,
  output reg [3:0] tx_slot,
  output reg rx_done,
  output reg [3:0] rx_slot,
  output reg [15:0] rx_word,
  output reg frame_start
);

  reg bclk_m; // first sync stage, bit clock
  reg bclk_s; // second sync stage
  reg bclk_d; // previous synced level for edge detect
  reg fs_m; // first sync stage, frame sync
  reg fs_s; // second sync stage
  reg fs_prev; // frame sync level at the previous rising bit clock edge
  reg sd_m; // first sync stage, serial data
  reg sd_s; // second sync stage
  reg active; // inside slots 0 to 15 of a frame
  reg [3:0] slot; // current slot
  reg [3:0] bitc; // bits left in current slot
  reg [15:0] txsh; // transmit shift register
  reg [15:0] rxsh; // receive shift register

  wire rise = bclk_s & ~bclk_d; // rising bit clock edge
  wire fall = ~bclk_s & bclk_d; // falling bit clock edge
  wire fstart = rise & fs_s & ~fs_prev; // frame begins at this edge

  // slot whose transmit word is fetched at this edge
  assign fetch_slot = fstart ? 4'h0 : slot + 4'h1;

  // two-flop synchronisers for every pin input
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bclk_m <= 1'b0;
      bclk_s <= 1'b0;
      bclk_d <= 1'b0;
      fs_m <= 1'b0;
      fs_s <= 1'b0;
      sd_m <= 1'b0;
      sd_s <= 1'b0;
    end else begin
      bclk_m <= bit_clk;
      bclk_s <= bclk_m;
      bclk_d <= bclk_s;
      fs_m <= frame_sync;
      fs_s <= fs_m;
      sd_m <= sdata_in;
      sd_s <= sd_m;
    end
  end

  // transmit side: drive on rising edges, fetch one word per slot
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fs_prev <= 1'b0;
      active <= 1'b0;
      slot <= 4'h0;
      bitc <= 4'h0;
      txsh <= 16'h0000;
      sdata_out <= 1'b0;
      tx_load <= 1'b0;
      tx_slot <= 4'h0;
      frame_start <= 1'b0;
    end else begin
      tx_load <= 1'b0;
      frame_start <= 1'b0;
      if (rise) begin
        fs_prev <= fs_s;
      end
      if (fstart) begin
        // slot 0 word is taken now; later writes wait a frame
        active <= 1'b1;
        slot <= 4'h0;
        bitc <= 4'hf;
        txsh <= tx_word;
        sdata_out <= tx_word[15];
        tx_load <= 1'b1;
        tx_slot <= 4'h0;
        frame_start <= 1'b1;
      end else if (rise && active) begin
        if (bitc == 4'h0) begin
          if (slot == 4'hf) begin
            // frame over, line idles low
            active <= 1'b0;
            sdata_out <= 1'b0;
          end else begin
            slot <= fetch_slot;
            bitc <= 4'hf;
            txsh <= tx_word;
            sdata_out <= tx_word[15];
            tx_load <= 1'b1;
            tx_slot <= fetch_slot;
          end
        end else begin
          bitc <= bitc - 4'h1;
          txsh <= {txsh[14:0], 1'b0};
          sdata_out <= txsh[14];
        end
      end
    end
  end

  // receive side: sample on falling edges, deliver whole words
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxsh <= 16'h0000;
      rx_done <= 1'b0;
      rx_slot <= 4'h0;
      rx_word <= 16'h0000;
    end else begin
      rx_done <= 1'b0;
      if (fall && active) begin
        rxsh <= {rxsh[14:0], sd_s};
        if (bitc == 4'h0) begin
          rx_done <= 1'b1;
          rx_slot <= slot;
          rx_word <= {rxsh[14:0], sd_s};
        end
      end
    end
  end

endmodule // acfs_shifter

// File: rtl/acfs_slot_handler.v
`timescale 1ns/1ps
`include "acfs_defines.vh"

// Functional notes
// RULE_01 - software zeroes transmit slots each frame
// RULE_02 - software checks slot 0 valid flags
// RULE_03 - below 48 kHz may read request flags
// RULE_04 - software sets transmit slot 0 tags
// RULE_05 - codec flags every frame valid at 48 kHz
// RULE_06 - software skips frames not flagged valid
// RULE_07 - receive done after all slots, then reload
// RULE_08 - transmit done once buffer moved to port
// RULE_09 - late slot 0 writes go next frame
// RULE_10 - single codec needs five slot buffers
// RULE_11 - port serves three stereo codecs, sixteen slots
// RULE_12 - sixteen transmit slots relax tag timing
// RULE_13 - software tracks valid and request separately
// RULE_14 - software uses only valid receive slots
// RULE_15 - left and right samples in slots 3, 4
// RULE_16 - tag 0xe000 marks slots 0 to 2 valid
// RULE_17 - software finishes transmit slots before slot 0
module acfs_slot_handler (
  // apb clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // serial link pins
  input wire bit_clk,
  input wire frame_sync,
  input wire sdata_in,
  output wire sdata_out,
  // frame events
  output reg rx_event,
  output reg tx_event
);

  reg [31:0] ctrl; // control: port enable
  reg [31:0] slot_en; // receive and transmit slot masks
  reg rx_done_flag; // sticky: receive buffer filled
  reg tx_done_flag; // sticky: transmit buffer moved out
  reg [15:0] rx_tag; // last slot 0 word received
  reg [31:0] frame_cnt; // frames started while the port is enabled
  reg [15:0] rx_buf [0:15]; // receive slot buffer
  reg [15:0] tx_buf [0:15]; // transmit slot buffer
  reg [31:0] next_prdata; // read data for the coming access phase
  reg next_pslverr; // error answer for the coming access phase
  reg [15:0] tx_word; // word offered to the shifter
  integer i; // transmit buffer index for its reset loop
  integer j; // receive buffer index for its reset loop

  wire [3:0] fetch_slot; // slot the shifter fetches now
  wire tx_load; // shifter took a transmit word
  wire [3:0] tx_slot; // slot of that word
  wire rx_done; // shifter delivered a receive word
  wire [3:0] rx_slot; // slot of that word
  wire [15:0] rx_word; // received word
  wire frame_start; // slot 0 started
  wire enable = ctrl[`ACFS_CTRL_ENABLE]; // port on
  wire [15:0] rx_mask = slot_en[15:0]; // active receive slots
  wire [15:0] tx_mask = slot_en[31:16]; // active transmit slots
  wire setup = psel & ~penable; // apb setup cycle
  wire access = psel & penable & pready; // apb write takes effect
  wire win_rx = (paddr[11:8] == 4'h0) && (paddr[7:6] == `ACFS_WIN_RX); // receive window
  wire win_tx = (paddr[11:8] == 4'h0) && (paddr[7:6] == `ACFS_WIN_TX); // transmit window
  wire [3:0] widx = paddr[5:2]; // word index inside a window
  wire clr_rx = access && pwrite && (paddr == `ACFS_OFF_STATUS) && pwdata[`ACFS_ST_RX_DONE]; // w1c
  wire clr_tx = access && pwrite && (paddr == `ACFS_OFF_STATUS) && pwdata[`ACFS_ST_TX_DONE]; // w1c
  wire rx_last = enable && rx_done && rx_mask[rx_slot] && (rx_slot == last_slot(rx_mask)); // buffer full
  wire tx_last = enable && tx_load && tx_mask[tx_slot] && (tx_slot == last_slot(tx_mask)); // buffer out

  // highest enabled slot of a mask; an empty mask gives slot 0
  function [3:0] last_slot;
    input [15:0] mask;
    integer k;
    begin
      last_slot = 4'h0;
      for (k = 0; k < 16; k = k + 1) begin
        if (mask[k]) begin
          last_slot = k[3:0];
        end
      end
    end
  endfunction

  // link shifter
  acfs_shifter u_shifter (
    .pclk(pclk),
    .presetn(presetn),
    .bit_clk(bit_clk),
    .frame_sync(frame_sync),
    .sdata_in(sdata_in),
    .sdata_out(sdata_out),
    .tx_word(tx_word),
    .fetch_slot(fetch_slot),
    .tx_load(tx_load),
    .tx_slot(tx_slot),
    .rx_done(rx_done),
    .rx_slot(rx_slot),
    .rx_word(rx_word),
    .frame_start(frame_start)
  );

  // transmit word: disabled slots or a stopped port send zeros
  always @* begin
    tx_word = 16'h0000;
    if (enable && tx_mask[fetch_slot]) begin
      tx_word = tx_buf[fetch_slot]; // RULE_09 RULE_11
    end
  end

  // apb read decode, prepared in the setup cycle
  always @* begin
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (paddr == `ACFS_OFF_CTRL) begin
      next_prdata = ctrl;
    end else if (paddr == `ACFS_OFF_SLOT_EN) begin
      next_prdata = slot_en;
    end else if (paddr == `ACFS_OFF_STATUS) begin
      next_prdata[`ACFS_ST_RX_DONE] = rx_done_flag;
      next_prdata[`ACFS_ST_TX_DONE] = tx_done_flag;
      next_prdata[`ACFS_ST_LEFT_VALID] = rx_tag[`ACFS_TAG_LEFT]; // RULE_15
      next_prdata[`ACFS_ST_RIGHT_VALID] = rx_tag[`ACFS_TAG_RIGHT]; // RULE_15
    end else if (paddr == `ACFS_OFF_RX_TAG) begin
      next_prdata = {16'h0000, rx_tag};
    end else if (paddr == `ACFS_OFF_FRAME_CNT) begin
      next_prdata = frame_cnt;
    end else if (win_rx && (paddr[1:0] == 2'b00)) begin
      next_prdata = {16'h0000, rx_buf[widx]};
    end else if (win_tx && (paddr[1:0] == 2'b00)) begin
      next_prdata = {16'h0000, tx_buf[widx]};
    end else begin
      // unmapped address answers with an error and zero data
      next_pslverr = 1'b1;
    end
  end

  // apb answer: one access cycle, no wait states
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      if (setup) begin
        prdata <= pwrite ? 32'h0000_0000 : next_prdata;
        pslverr <= next_pslverr;
      end else begin
        prdata <= 32'h0000_0000;
        pslverr <= 1'b0;
      end
    end
  end

  // control and slot enable registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `ACFS_CTRL_RST;
      slot_en <= `ACFS_SLOT_EN_RST; // RULE_10
    end else if (access && pwrite) begin
      if (paddr == `ACFS_OFF_CTRL) begin
        ctrl <= {31'h0000_0000, pwdata[`ACFS_CTRL_ENABLE]};
      end else if (paddr == `ACFS_OFF_SLOT_EN) begin
        slot_en <= pwdata; // RULE_11
      end
    end
  end

  // transmit buffer: software writes words, shifter reads them
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < 16; i = i + 1) begin
        tx_buf[i] <= 16'h0000;
      end
    end else if (access && pwrite && win_tx && (paddr[1:0] == 2'b00)) begin
      tx_buf[widx] <= pwdata[15:0];
    end
  end

  // receive buffer: each active slot lands at its own index
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (j = 0; j < 16; j = j + 1) begin
        rx_buf[j] <= 16'h0000;
      end
      rx_tag <= 16'h0000;
    end else if (enable && rx_done && rx_mask[rx_slot]) begin
      rx_buf[rx_slot] <= rx_word; // RULE_07 RULE_15
      if (rx_slot == 4'h0) begin
        rx_tag <= rx_word; // RULE_05
      end
    end
  end

  // frame events and sticky flags; a new event beats a clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_event <= 1'b0;
      tx_event <= 1'b0;
      rx_done_flag <= 1'b0;
      tx_done_flag <= 1'b0;
      frame_cnt <= 32'h0000_0000;
    end else begin
      rx_event <= rx_last; // RULE_07
      tx_event <= tx_last; // RULE_08
      rx_done_flag <= rx_last | (rx_done_flag & ~clr_rx); // RULE_07
      tx_done_flag <= tx_last | (tx_done_flag & ~clr_tx); // RULE_08
      if (frame_start && enable) begin
        frame_cnt <= frame_cnt + 32'h0000_0001;
      end
    end
  end

endmodule // acfs_slot_handler

// File: verif/acfs_codec_model.sv
`timescale 1ns/1ps
// codec side: frames the link on request, bit clock still between frames
module acfs_codec_model (
  // bench control
  input wire go,
  input wire [255:0] frame_in,
  output logic [255:0] frame_out,
  output logic busy,
  // link pins
  input wire sdata_out,
  output logic bit_clk,
  output logic frame_sync,
  output logic sdata_in
);
  initial begin
    bit_clk = 1'b0;
    frame_sync = 1'b0;
    sdata_in = 1'b0;
    busy = 1'b0;
    frame_out = '0;
  end
  // one frame: 16 slots of 16 bits, msb first, 80 ns bit period
  always @(posedge go) begin
    busy = 1'b1;
    frame_sync = 1'b1;
    #40;
    for (int i = 0; i < 256; i++) begin
      bit_clk = 1'b1;
      sdata_in = frame_in[255-i];
      #40;
      bit_clk = 1'b0;
      frame_out[255-i] = sdata_out;
      if (i == 15) frame_sync = 1'b0;
      #40;
    end
    // released line shows the inverse of its last bit
    sdata_in = ~sdata_in;
    busy = 1'b0;
  end
endmodule // acfs_codec_model

// File: verif/acfs_props.sv
`timescale 1ns/1ps
// watches the apb answer and the link output of the slot handler
module acfs_props (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb
  input wire psel,
  input wire penable,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // link and events
  input wire bit_clk,
  input wire sdata_out,
  input wire rx_event,
  input wire tx_event
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // zero wait states: answer in the cycle after setup
  rdy_after_setup_a: assert property (psel && !penable |=> pready && penable)
    else $error("no ready after setup");
  rdy_in_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  rdy_one_cycle_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  err_zero_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error with data or no ready");
  idle_zero_data_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  rx_event_pulse_a: assert property (rx_event |=> !rx_event)
    else $error("receive event too long");
  tx_event_pulse_a: assert property (tx_event |=> !tx_event)
    else $error("transmit event too long");
  // the output bit moves only just after a rising bit clock
  out_on_rise_a: assert property ($changed(sdata_out) |-> bit_clk)
    else $error("serial out moved off the rising edge");
  cover property (rx_event);
  cover property (tx_event);
  cover property (pslverr);
endmodule // acfs_props

bind acfs_slot_handler acfs_props acfs_props_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bit_clk(bit_clk),
  .sdata_out(sdata_out), .rx_event(rx_event), .tx_event(tx_event));

// File: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  // apb drive and design outputs
  logic pclk, presetn, psel, penable, pwrite, go, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd, rs, mask, late;
  logic [255:0] fin;
  logic [15:0] txv [16];
  wire [31:0] prdata;
  wire [255:0] fout;
  wire pready, pslverr, bit_clk, frame_sync, sdata_in, sdata_out, rx_event, tx_event, busy;
  int failures, compares, rxn, txn, k, n;

  acfs_slot_handler acfs_slot_handler_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bit_clk(bit_clk), .frame_sync(frame_sync), .sdata_in(sdata_in), .sdata_out(sdata_out),
    .rx_event(rx_event), .tx_event(tx_event));
  acfs_codec_model acfs_codec_model_inst (.go(go), .frame_in(fin), .frame_out(fout), .busy(busy),
    .sdata_out(sdata_out), .bit_clk(bit_clk), .frame_sync(frame_sync), .sdata_in(sdata_in));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // count event pulses per frame
  always @(posedge pclk) begin
    if (rx_event === 1'b1) rxn++;
    if (tx_event === 1'b1) txn++;
  end
  // xorshift source
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  // expected bits of a sent slot and a stored slot
  function automatic logic [31:0] exp_tx(int s);
    return mask[16+s] ? {16'h0, txv[s]} : 32'h0;
  endfunction
  function automatic logic [31:0] exp_rx(int s);
    return mask[s] ? {16'h0, fin[255-16*s -: 16]} : 32'h0;
  endfunction
  task tally_and_finish();
    if (failures == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // one apb transfer, held until pready is seen
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i >= 20) begin
      failures++;
      tally_and_finish();
    end
  endtask
  task rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // one link frame from the codec model
  task frame();
    int i;
    rxn = 0;
    txn = 0;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while ((busy !== 1'b0 || i < 3) && i < 8000);
    if (i >= 8000) begin
      failures++;
      tally_and_finish();
    end
    repeat (20) @(posedge pclk);
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    go = 1'b0;
    fin = '0;
    rs = 32'd28448;
    mask = 32'h001f_001f;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rchk(12'h000, 32'h0);
    rchk(12'h004, 32'h001f_001f);
    rchk(12'h008, 32'h0);
    apb(1'b0, 12'h100, 32'h0);
    chk({31'h0, err}, 32'h1);
    // disabled port sends zeros and raises nothing
    apb(1'b1, 12'h080, 32'h1234);
    frame();
    chk(fout[255 -: 32], 32'h0);
    chk(rxn + txn, 0);
    apb(1'b1, 12'h000, 32'h1);
    for (k = 0; k < 3; k++) begin
      if (k == 2) begin
        mask = 32'hffff_ffff;
        apb(1'b1, 12'h004, mask);
      end
      for (n = 0; n < 16; n++) fin[255-16*n -: 16] = rnd();
      // left and right valid drawn apart, as a codec below 48 kHz
      fin[255 -: 16] = {1'b1, 2'b0, fin[252:251], 11'h0};
      // slot 0 keeps the late word on the last pass
      for (n = (k == 2); n < 16; n++) begin
        txv[n] = 16'h0;
        apb(1'b1, 12'(12'h080 + 4 * n), 32'h0);
      end
      for (n = (k == 2); n < 16; n++) begin
        txv[n] = (n == 0) ? (16'he000 | {3'h0, fin[252:251], 11'h0}) : 16'(rnd());
        apb(1'b1, 12'(12'h080 + 4 * n), {16'h0, txv[n]});
      end
      if (k == 1) begin
        // slot 0 rewritten after its fetch
        fork
          frame();
          begin
            repeat (400) @(posedge pclk);
            late = rnd();
            apb(1'b1, 12'h080, {16'h0, late[15:0]});
          end
        join
      end else frame();
      for (n = 0; n < 16; n++) begin
        chk(fout[255-16*n -: 16], exp_tx(n));
        rchk(12'(12'h040 + 4 * n), exp_rx(n));
      end
      chk(rxn, 1);
      chk(txn, 1);
      rchk(12'h00c, {16'h0, fin[255 -: 16]});
      rchk(12'h008, {28'h0, fin[251], fin[252], 2'b11});
      // samples are taken only from slots flagged valid
      if (fin[252]) rchk(12'h04c, exp_rx(3));
      if (fin[251]) rchk(12'h050, exp_rx(4));
      rchk(12'h0bc, {16'h0, txv[15]});
      apb(1'b1, 12'h008, 32'h3);
      rchk(12'h008, {28'h0, fin[251], fin[252], 2'b00});
      rchk(12'h010, k + 1);
      if (k == 1) txv[0] = late[15:0];
    end
    // receive window ignores writes
    apb(1'b1, 12'h044, 32'hffff);
    rchk(12'h044, exp_rx(1));
    tally_and_finish();
  end
endmodule // tb_top
